// ---- design/cit_pkg.sv ----
//Contract
// - The external-space move reads and writes on-chip program memory.
// - No path exists to external data or program memory.
// - Register-operand arithmetic, logic, move, increment and decrement: 1 byte, 1 cycle.
// - Direct or immediate operand into accumulator: 2 bytes, 2 cycles.
// - Indirect RAM operand or its increment and decrement: 1 byte, 2 cycles.
// - Add-with-carry and subtract-with-borrow take the carry flag as input.
// - Accumulator into direct byte, or direct increment and decrement: 2 bytes, 2 cycles.
// - Logical immediate into direct byte: 3 bytes, 3 cycles.
// - Accumulator-only operations and pointer increment: 1 byte, 1 cycle.
// - Direct or immediate into register; byte moves into direct: 2 bytes, 2 cycles.
// - Direct to direct, or immediate to direct: 3 bytes, 3 cycles.
// - Accumulator store to indirect RAM: 1 byte, 2 cycles.
// - Direct or immediate store to indirect RAM: 2 bytes, 2 cycles.
// - Load 16-bit data pointer with constant: 3 bytes, 3 cycles.
// - Code byte read at pointer plus accumulator: 1 byte, 3 cycles.
// - Times count system clocks; no instruction exceeds eight cycles.
// - No machine-cycle grouping; timing is pure clock counts per instruction.
package cit_pkg;

	// ****************************************
	// Widths and counts
	// ****************************************
	localparam int unsigned CIT_LEN_W = 2;
	localparam int unsigned CIT_CYC_W = 4;

	localparam logic [CIT_LEN_W-1:0] CIT_LEN_1 = 2'h1;
	localparam logic [CIT_LEN_W-1:0] CIT_LEN_2 = 2'h2;
	localparam logic [CIT_LEN_W-1:0] CIT_LEN_3 = 2'h3;

	localparam logic [CIT_CYC_W-1:0] CIT_CYC_1   = 4'h1;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_2   = 4'h2;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_3   = 4'h3;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_4   = 4'h4;
	localparam logic [CIT_CYC_W-1:0] CIT_CYC_MAX = 4'h8;

	// ****************************************
	// Opcode fields
	// ****************************************
	localparam int unsigned CIT_HI_MSB = 7;
	localparam int unsigned CIT_HI_LSB = 4;
	localparam int unsigned CIT_LO_MSB = 3;
	localparam int unsigned CIT_LO_LSB = 0;

	// Opcode rows
	localparam logic [3:0] CIT_ROW_INC  = 4'h0;
	localparam logic [3:0] CIT_ROW_DEC  = 4'h1;
	localparam logic [3:0] CIT_ROW_ADD  = 4'h2;
	localparam logic [3:0] CIT_ROW_SUM_WITH_CARRY = 4'h3;
	localparam logic [3:0] CIT_ROW_OR   = 4'h4;
	localparam logic [3:0] CIT_ROW_AND  = 4'h5;
	localparam logic [3:0] CIT_ROW_XOR  = 4'h6;
	localparam logic [3:0] CIT_ROW_SUBTRACT_WITH_BORROW = 4'h9;

	// Low nibble operand columns
	localparam logic [3:0] CIT_COL_DIR_A   = 4'h2;
	localparam logic [3:0] CIT_COL_DIR_IMM = 4'h3;
	localparam logic [3:0] CIT_COL_IMM     = 4'h4;
	localparam logic [3:0] CIT_COL_DIR     = 4'h5;
	localparam logic [3:0] CIT_COL_IND0    = 4'h6;
	localparam logic [3:0] CIT_COL_IND1    = 4'h7;

	// Single opcodes
	localparam logic [7:0] CIT_OP_RR       = 8'h03;
	localparam logic [7:0] CIT_OP_RRC      = 8'h13;
	localparam logic [7:0] CIT_OP_RL       = 8'h23;
	localparam logic [7:0] CIT_OP_RLC      = 8'h33;
	localparam logic [7:0] CIT_OP_MOV_A_I  = 8'h74;
	localparam logic [7:0] CIT_OP_MOV_D_I  = 8'h75;
	localparam logic [7:0] CIT_OP_DIV      = 8'h84;
	localparam logic [7:0] CIT_OP_MOV_D_D  = 8'h85;
	localparam logic [7:0] CIT_OP_MOV_DATA_POINTER_16 = 8'h90;
	localparam logic [7:0] CIT_OP_CODE_RD  = 8'h93;
	localparam logic [7:0] CIT_OP_INC_DATA_POINTER_16 = 8'hA3;
	localparam logic [7:0] CIT_OP_MUL      = 8'hA4;
	localparam logic [7:0] CIT_OP_SWAP     = 8'hC4;
	localparam logic [7:0] CIT_OP_DA       = 8'hD4;
	localparam logic [7:0] CIT_OP_XMV_RD_P = 8'hE0;
	localparam logic [7:0] CIT_OP_CLR_A    = 8'hE4;
	localparam logic [7:0] CIT_OP_MOV_A_D  = 8'hE5;
	localparam logic [7:0] CIT_OP_XMV_WR_P = 8'hF0;
	localparam logic [7:0] CIT_OP_CPL_A    = 8'hF4;
	localparam logic [7:0] CIT_OP_MOV_D_A  = 8'hF5;

	// Opcode families differing only in the low register select
	localparam logic [6:0] CIT_FAM_XMV_RD_I = 7'h71;
	localparam logic [6:0] CIT_FAM_XMV_WR_I = 7'h79;
	localparam logic [6:0] CIT_FAM_A_IND    = 7'h73;
	localparam logic [6:0] CIT_FAM_IND_A    = 7'h7B;
	localparam logic [6:0] CIT_FAM_IND_I    = 7'h3B;
	localparam logic [6:0] CIT_FAM_D_IND    = 7'h43;
	localparam logic [6:0] CIT_FAM_IND_D    = 7'h53;
	localparam logic [4:0] CIT_FAM_R_IMM    = 5'h0F;
	localparam logic [4:0] CIT_FAM_D_R      = 5'h11;
	localparam logic [4:0] CIT_FAM_R_D      = 5'h15;
	localparam logic [4:0] CIT_FAM_A_R      = 5'h1D;
	localparam logic [4:0] CIT_FAM_R_A      = 5'h1F;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		CIT_SPC_NONE = 2'h0,
		CIT_SPC_IRAM = 2'h1,
		CIT_SPC_CODE = 2'h2
	} cit_space_t;

	typedef struct packed {
		logic                 known;
		logic                 carry_in;
		cit_space_t           space;
		logic [CIT_LEN_W-1:0] len;
		logic [CIT_CYC_W-1:0] cyc;
	} cit_dec_t;

	localparam cit_dec_t CIT_DEC_RST = '{known: 1'b0, carry_in: 1'b0, space: CIT_SPC_NONE,
		len: CIT_LEN_1, cyc: CIT_CYC_1};
	localparam logic [CIT_CYC_W-1:0] CIT_CNT_RST = 4'h0;

endpackage : cit_pkg

// ---- design/cit_core.sv ----
module cit_core
	import cit_pkg::*;
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	// Opcode issue
	input  wire logic                 op_vld,
	input  wire logic [7:0]           op_byte,
	output      logic                 op_rdy_ff,
	// Decoded timing
	output      cit_dec_t             dec_ff,
	output      logic                 busy_ff,
	output      logic                 last_ff
);

	// ****************************************
	// Decode
	// ****************************************
	cit_dec_t   dec;
	logic [3:0] hi;
	logic [3:0] lo;

	assign hi = op_byte[CIT_HI_MSB:CIT_HI_LSB];
	assign lo = op_byte[CIT_LO_MSB:CIT_LO_LSB];

	// Fixed table on opcode only, never on data or flags
	always_comb begin
		dec       = CIT_DEC_RST;
		dec.known = 1'b1;
		dec.space = CIT_SPC_IRAM;
		unique case (hi)
			CIT_ROW_ADD, CIT_ROW_SUM_WITH_CARRY, CIT_ROW_SUBTRACT_WITH_BORROW, CIT_ROW_OR, CIT_ROW_AND, CIT_ROW_XOR: begin
				// Low columns of these rows are rotates, jumps and pointer forms, not add or subtract
				dec.carry_in = ((hi == CIT_ROW_SUM_WITH_CARRY) || (hi == CIT_ROW_SUBTRACT_WITH_BORROW)) && (lo >= CIT_COL_IMM);
			end
			default: begin
			end
		endcase
		// Arithmetic and logical accumulator forms share one column layout
		if ((hi == CIT_ROW_ADD) || (hi == CIT_ROW_SUM_WITH_CARRY) || (hi == CIT_ROW_SUBTRACT_WITH_BORROW) ||
			(hi == CIT_ROW_OR) || (hi == CIT_ROW_AND) || (hi == CIT_ROW_XOR)) begin
			if (lo[3]) begin
				dec.len = CIT_LEN_1;
				dec.cyc = CIT_CYC_1;
			end else if ((lo == CIT_COL_IMM) || (lo == CIT_COL_DIR)) begin
				dec.len = CIT_LEN_2;
				dec.cyc = CIT_CYC_2;
			end else if ((lo == CIT_COL_IND0) || (lo == CIT_COL_IND1)) begin
				dec.len = CIT_LEN_1;
				dec.cyc = CIT_CYC_2;
			end else if ((hi == CIT_ROW_OR || hi == CIT_ROW_AND || hi == CIT_ROW_XOR) &&
				(lo == CIT_COL_DIR_A)) begin
				dec.len = CIT_LEN_2;
				dec.cyc = CIT_CYC_2;
			end else if ((hi == CIT_ROW_OR || hi == CIT_ROW_AND || hi == CIT_ROW_XOR) &&
				(lo == CIT_COL_DIR_IMM)) begin
				dec.len = CIT_LEN_3;
				dec.cyc = CIT_CYC_3;
			end else if (op_byte == CIT_OP_RL || op_byte == CIT_OP_RLC) begin
				dec.cyc = CIT_CYC_1;
			end else if (op_byte == CIT_OP_MOV_DATA_POINTER_16) begin
				// Pointer load and code read sit in the borrow-subtract row
				dec.len = CIT_LEN_3;
				dec.cyc = CIT_CYC_3;
			end else if (op_byte == CIT_OP_CODE_RD) begin
				dec.space = CIT_SPC_CODE;
				dec.cyc   = CIT_CYC_3;
			end else begin
				dec = CIT_DEC_RST;
			end
		end else if ((hi == CIT_ROW_INC) || (hi == CIT_ROW_DEC)) begin
			if (lo[3] || (lo == CIT_COL_IMM)) begin
				dec.cyc = CIT_CYC_1;
			end else if (lo == CIT_COL_DIR) begin
				dec.len = CIT_LEN_2;
				dec.cyc = CIT_CYC_2;
			end else if ((lo == CIT_COL_IND0) || (lo == CIT_COL_IND1)) begin
				dec.cyc = CIT_CYC_2;
			end else if (op_byte == CIT_OP_RR || op_byte == CIT_OP_RRC) begin
				dec.cyc = CIT_CYC_1;
			end else begin
				dec = CIT_DEC_RST;
			end
		end else if (op_byte[7:3] == CIT_FAM_A_R || op_byte[7:3] == CIT_FAM_R_A) begin
			dec.cyc = CIT_CYC_1;
		end else if (op_byte == CIT_OP_MOV_A_I || op_byte == CIT_OP_MOV_A_D) begin
			dec.len = CIT_LEN_2;
			dec.cyc = CIT_CYC_2;
		end else if (op_byte[7:1] == CIT_FAM_A_IND) begin
			dec.cyc = CIT_CYC_2;
		end else if (op_byte == CIT_OP_CLR_A || op_byte == CIT_OP_CPL_A || op_byte == CIT_OP_SWAP ||
			op_byte == CIT_OP_DA || op_byte == CIT_OP_INC_DATA_POINTER_16) begin
			dec.cyc = CIT_CYC_1;
		end else if (op_byte[7:3] == CIT_FAM_R_IMM || op_byte[7:3] == CIT_FAM_R_D ||
			op_byte[7:3] == CIT_FAM_D_R || op_byte == CIT_OP_MOV_D_A ||
			op_byte[7:1] == CIT_FAM_D_IND) begin
			dec.len = CIT_LEN_2;
			dec.cyc = CIT_CYC_2;
		end else if (op_byte == CIT_OP_MOV_D_D || op_byte == CIT_OP_MOV_D_I) begin
			dec.len = CIT_LEN_3;
			dec.cyc = CIT_CYC_3;
		end else if (op_byte[7:1] == CIT_FAM_IND_A) begin
			dec.cyc = CIT_CYC_2;
		end else if (op_byte[7:1] == CIT_FAM_IND_D || op_byte[7:1] == CIT_FAM_IND_I) begin
			dec.len = CIT_LEN_2;
			dec.cyc = CIT_CYC_2;
		end else if (op_byte == CIT_OP_XMV_RD_P || op_byte == CIT_OP_XMV_WR_P ||
			op_byte[7:1] == CIT_FAM_XMV_RD_I || op_byte[7:1] == CIT_FAM_XMV_WR_I) begin
			// No external bus exists; the move lands in on-chip program store
			dec.space = CIT_SPC_CODE;
			dec.cyc   = CIT_CYC_3;
		end else if (op_byte == CIT_OP_MUL) begin
			dec.cyc = CIT_CYC_4;
		end else if (op_byte == CIT_OP_DIV) begin
			dec.cyc = CIT_CYC_MAX;
		end else begin
			dec = CIT_DEC_RST;
		end
	end

	// ****************************************
	// Cycle sequencer
	// ****************************************
	typedef enum logic [1:0] {
		CIT_ST_IDLE = 2'b01,
		CIT_ST_EXEC = 2'b10
	} cit_state_t;

	cit_state_t           st_ff;
	cit_state_t           nxt_st;
	logic [CIT_CYC_W-1:0] cnt_ff;
	logic [CIT_CYC_W-1:0] nxt_cnt;
	cit_dec_t             nxt_dec;
	logic                 nxt_rdy;
	logic                 nxt_busy;
	logic                 nxt_last;
	logic                 take;

	assign take = op_vld && op_rdy_ff;

	// One count per system clock, no grouping into machine cycles
	always_comb begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		nxt_dec = dec_ff;
		unique case (st_ff)
			CIT_ST_IDLE: begin
				if (take) begin
					nxt_st  = CIT_ST_EXEC;
					nxt_cnt = dec.cyc;
					nxt_dec = dec;
				end
			end
			CIT_ST_EXEC: begin
				// Back-to-back issue in the final cycle keeps the pipe full
				if (take) begin
					nxt_cnt = dec.cyc;
					nxt_dec = dec;
				end else if (cnt_ff == CIT_CYC_1) begin
					nxt_st  = CIT_ST_IDLE;
					nxt_cnt = CIT_CNT_RST;
				end else begin
					nxt_cnt = cnt_ff - CIT_CYC_1;
				end
			end
		endcase
		nxt_busy = (nxt_st == CIT_ST_EXEC);
		nxt_last = nxt_busy && (nxt_cnt == CIT_CYC_1);
		nxt_rdy  = !nxt_busy || nxt_last;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff     <= CIT_ST_IDLE;
			cnt_ff    <= CIT_CNT_RST;
			dec_ff    <= CIT_DEC_RST;
			busy_ff   <= 1'b0;
			last_ff   <= 1'b0;
			op_rdy_ff <= 1'b1;
		end else begin
			st_ff     <= nxt_st;
			cnt_ff    <= nxt_cnt;
			dec_ff    <= nxt_dec;
			busy_ff   <= nxt_busy;
			last_ff   <= nxt_last;
			op_rdy_ff <= nxt_rdy;
		end
	end

endmodule : cit_core

// ---- bench/cit_core_chk.sv ----
// ********
// Timing checker
// ********
module cit_core_chk
	import cit_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_b,
	// Opcode issue
	input wire logic       op_vld,
	input wire logic [7:0] op_byte,
	input wire logic       op_rdy_ff,
	// Decoded timing
	input wire cit_dec_t   dec_ff,
	input wire logic       busy_ff,
	input wire logic       last_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	logic tk;
	logic ci_exp;
	assign tk     = op_vld && op_rdy_ff;
	// Columns below 4 of these rows are other forms
	assign ci_exp = (op_byte[7:4] == CIT_ROW_SUM_WITH_CARRY || op_byte[7:4] == CIT_ROW_SUBTRACT_WITH_BORROW) && op_byte[3:0] > 4'h3;

	chk_take_busy: assert property (tk |=> busy_ff) else $error("take gave no busy");
	chk_rdy_idle: assert property (op_rdy_ff == (!busy_ff || last_ff)) else $error("ready wrong");
	chk_cyc_max: assert property (busy_ff |-> dec_ff.cyc inside {[CIT_CYC_1:CIT_CYC_MAX]})
		else $error("cycle count out of range");
	chk_one_cyc: assert property (tk ##1 dec_ff.cyc == CIT_CYC_1 |-> last_ff) else $error("1-cycle late");
	chk_two_cyc: assert property (tk ##1 dec_ff.cyc == CIT_CYC_2 |-> !last_ff ##1 last_ff)
		else $error("2-cycle wrong");
	chk_three_cyc: assert property (tk ##1 dec_ff.cyc == CIT_CYC_3 |-> (!last_ff)[*2] ##1 last_ff)
		else $error("3-cycle wrong");
	chk_eight_cyc: assert property (tk && op_byte == CIT_OP_DIV |=> (!last_ff)[*7] ##1 last_ff)
		else $error("divide not 8 cycles");
	chk_xmv_code: assert property (tk && op_byte inside {8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3}
		|=> dec_ff.space == CIT_SPC_CODE) else $error("external move not on-chip");
	chk_carry_in: assert property (tk && ci_exp |=> dec_ff.carry_in) else $error("carry unused");
	chk_dec_hold: assert property (!tk |=> $stable(dec_ff)) else $error("decode moved");
	chk_no_ext: assert property (dec_ff.space != 2'h3) else $error("external space");

	cover property (tk && op_byte == CIT_OP_DIV);
	cover property (tk && last_ff);
	cover property (op_vld && !op_rdy_ff);
endmodule : cit_core_chk

// ---- bench/cit_op_src.sv ----
// ********
// Opcode source standing for program memory
// ********
module cit_op_src
	import cit_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	// Bench request
	input  wire logic       go,
	input  wire logic [7:0] go_byte,
	output      logic       took,
	// Opcode issue
	input  wire logic       op_rdy_ff,
	output      logic       op_vld,
	output      logic [7:0] op_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial {op_vld, op_byte, took} = 10'h000;
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) took <= 1'b0;
		else took <= op_vld && op_rdy_ff;
	end
	// Offer held until taken; idle byte toggles so stale data is never mistaken
	always @(negedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_vld  <= 1'b0;
			op_byte <= 8'h00;
		end else if (op_vld && !took) begin
			op_vld <= 1'b1;
		end else if (go) begin
			op_vld  <= 1'b1;
			op_byte <= go_byte;
		end else begin
			op_vld  <= 1'b0;
			op_byte <= ~op_byte;
		end
	end
endmodule : cit_op_src

// ---- bench/cit_core_tb.sv ----
module cit_core_tb
	import cit_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       core_clk = 1'b0;
	logic       rst_b    = 1'b0;
	logic       go       = 1'b0;
	logic [7:0] go_byte  = 8'h00;
	logic       took, op_vld, op_rdy_ff, busy_ff, last_ff;
	logic [7:0] op_byte;
	cit_dec_t   dec_ff;
	int         fails    = 0;
	int         n_checks = 0;

	cit_op_src src (.core_clk(core_clk), .rst_b(rst_b), .go(go), .go_byte(go_byte), .took(took),
		.op_rdy_ff(op_rdy_ff), .op_vld(op_vld), .op_byte(op_byte));
	cit_core dut (.core_clk(core_clk), .rst_b(rst_b), .op_vld(op_vld), .op_byte(op_byte),
		.op_rdy_ff(op_rdy_ff), .dec_ff(dec_ff), .busy_ff(busy_ff), .last_ff(last_ff));

	initial forever #4 core_clk = ~core_clk;

	task automatic ck(input string nm, input logic [9:0] exp, input logic [9:0] got);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask : ck

	task automatic close_out();
		if (fails == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out

	task automatic do_rst();
		rst_b = 1'b0;
		repeat (10) @(negedge core_clk);
		rst_b = 1'b1;
		ck("reset dec", CIT_DEC_RST, dec_ff);
		ck("reset flags", 10'h004, {7'h00, op_rdy_ff, busy_ff, last_ff});
	endtask : do_rst

	// Time is counted from the first busy cycle to the one showing last
	task automatic op(input logic [7:0] b, input logic [1:0] l, input logic [3:0] c, input cit_space_t sp);
		int n;
		logic ci;
		ci = (b[7:4] == CIT_ROW_SUM_WITH_CARRY || b[7:4] == CIT_ROW_SUBTRACT_WITH_BORROW) && b[3:0] > 4'h3;
		go <= 1'b1;
		go_byte <= b;
		@(negedge core_clk);
		go <= 1'b0;
		@(negedge core_clk);
		ck("taken", 10'h001, {9'h000, took});
		ck("dec", {1'b1, ci, sp, l, c}, dec_ff);
		n = 1;
		while (last_ff !== 1'b1 && n < 10) begin
			@(negedge core_clk);
			n++;
		end
		ck("cycles", 10'(c), 10'(n));
		@(negedge core_clk);
		ck("idle", 10'h000, {9'h000, busy_ff});
	endtask : op

	task automatic grp(input logic [7:0] q[$], input logic [1:0] l, input logic [3:0] c, input cit_space_t sp);
		foreach (q[i]) op(q[i], l, c, sp);
	endtask : grp

	// Second opcode offered while busy must wait for the last cycle
	task automatic btb();
		logic [3:0] bv, lv;
		go <= 1'b1;
		go_byte <= 8'h24;
		@(negedge core_clk);
		go_byte <= 8'h28;
		@(negedge core_clk);
		go <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			bv[i] = busy_ff;
			lv[i] = last_ff;
			@(negedge core_clk);
		end
		ck("btb busy", 10'h007, {6'h00, bv});
		ck("btb last", 10'h006, {6'h00, lv});
		ck("btb dec", {1'b1, 1'b0, CIT_SPC_IRAM, CIT_LEN_1, CIT_CYC_1}, dec_ff);
	endtask : btb

	task automatic rst_mid();
		go <= 1'b1;
		go_byte <= CIT_OP_DIV;
		@(negedge core_clk);
		go <= 1'b0;
		repeat (3) @(negedge core_clk);
		do_rst();
	endtask : rst_mid

	initial begin
		do_rst();
		grp('{8'h28, 8'h3F, 8'h98, 8'h59, 8'h4A, 8'h6B, 8'hE8, 8'hF8, 8'h08, 8'h1F}, 2'h1, 4'h1, CIT_SPC_IRAM);
		grp('{8'h25, 8'h34, 8'h95, 8'h54, 8'h45, 8'h64, 8'hE5, 8'h74}, 2'h2, 4'h2, CIT_SPC_IRAM);
		grp('{8'h26, 8'h37, 8'h97, 8'h56, 8'h46, 8'h66, 8'hE6, 8'h06, 8'h17}, 2'h1, 4'h2, CIT_SPC_IRAM);
		grp('{8'h52, 8'h42, 8'h62, 8'h05, 8'h15}, 2'h2, 4'h2, CIT_SPC_IRAM);
		grp('{8'h53, 8'h43, 8'h63}, 2'h3, 4'h3, CIT_SPC_IRAM);
		grp('{8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4, 8'hD4, 8'hA3, 8'h04}, 2'h1, 4'h1, CIT_SPC_IRAM);
		grp('{8'hA8, 8'h78, 8'hF5, 8'h88, 8'h86}, 2'h2, 4'h2, CIT_SPC_IRAM);
		grp('{8'h85, 8'h75}, 2'h3, 4'h3, CIT_SPC_IRAM);
		grp('{8'hF6, 8'hF7}, 2'h1, 4'h2, CIT_SPC_IRAM);
		grp('{8'hA6, 8'h76}, 2'h2, 4'h2, CIT_SPC_IRAM);
		op(8'h90, 2'h3, 4'h3, CIT_SPC_IRAM);
		op(8'h93, 2'h1, 4'h3, CIT_SPC_CODE);
		grp('{8'hE0, 8'hF0, 8'hE2, 8'hF3}, 2'h1, 4'h3, CIT_SPC_CODE);
		op(CIT_OP_DIV, 2'h1, 4'h8, CIT_SPC_IRAM);
		op(CIT_OP_MUL, 2'h1, 4'h4, CIT_SPC_IRAM);
		btb();
		rst_mid();
		close_out();
	end
endmodule : cit_core_tb

bind cit_core cit_core_chk chk (.core_clk(core_clk), .rst_b(rst_b), .op_vld(op_vld), .op_byte(op_byte),
	.op_rdy_ff(op_rdy_ff), .dec_ff(dec_ff), .busy_ff(busy_ff), .last_ff(last_ff));
